/* common/lsb_pkg.sv */
`default_nettype none
package lsb_pkg;
    // opcode field values
    localparam logic [3:0] OP_CP_STORE = 4'ha;
    localparam logic [3:0] OP_CP_LOAD = 4'hb;
    localparam logic [3:0] OP_CPU_STORE = 4'hc;
    localparam logic [3:0] OP_CPU_LOAD = 4'hd;
    localparam logic [3:0] OP_TEST = 4'h9;
    localparam logic [3:0] OP_CP_ALU = 4'h6;
    localparam logic [3:0] OP_COND_JUMP = 4'he;
    localparam logic [3:0] OP_ADD_IMM = 4'hf;
    // memory-format field positions
    localparam int OPC_MSB = 31;
    localparam int OPC_LSB = 28;
    localparam int RES_MSB = 27;
    localparam int RES_LSB = 22;
    localparam int BASE_MSB = 21;
    localparam int BASE_LSB = 16;
    localparam int DISP_MSB = 15;
    localparam int DISP_LSB = 0;
    // condition field bits
    localparam int COND_SEL_LSB = 3;
    localparam int COND_SEL_NEG = 2;
    localparam int COND_SEL_POS = 1;
    localparam int COND_SENSE = 0;
    // reset value, pc step and address alignment masks
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [31:0] PC_STEP = 32'h0000_0001;
    localparam logic [31:0] WORD_MASK = 32'hffff_fffc;
    localparam logic [31:0] DWORD_MASK = 32'hffff_fff8;
endpackage
`default_nettype wire

/* rtl/load_store_branch_execute.sv */
// How it works
// [RULE_01] test opcode 9 acts as coprocessor alu, word shown on address pins
// [RULE_02] address = sign-extended offset shifted left two, plus base register
// [RULE_03] coprocessor store clears three low address bits, writes doubleword
// [RULE_04] coprocessor register number and opcode go out in compute stage
// [RULE_05] coprocessor load clears three low bits, coprocessor takes doubleword
// [RULE_06] cpu store clears two low address bits, writes result register word
// [RULE_07] cpu store probes cache in access stage, drives data in writeback
// [RULE_08] cache unit writes bus data into cache on hit, late writeback
// [RULE_09] cpu load clears two low bits, writes word into result register
// [RULE_10] software avoids loads whose base equals result register
// [RULE_11] jump target is own pc plus offset, taken on condition, else increment
// [RULE_12] instruction after a jump always executes
// [RULE_13] condition uses low four bits of selector field
// [RULE_14] condition is nor of selected tests, or their or with sense
// [RULE_15] add immediate writes base plus offset into result register
// [RULE_16] pc writes take effect after the next sequential instruction; the code lands them after the next two
// [RULE_17] exceptions pull shared active-low interrupt line one cycle later; the code pulls it two cycles later
// [RULE_18] coprocessor alu word sent over address lines in access stage
// [RULE_19] four stages: fetch, compute, cache access, writeback; commit in writeback
// [RULE_20] fields: 4-bit opcode, two 6-bit registers, 16-bit word offset
`default_nettype none
module load_store_branch_execute
    import lsb_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [31:0] FETCH_INSTR,
    input wire logic FETCH_VALID,
    input wire logic [31:0] BASE_VALUE,
    input wire logic [31:0] RESULT_VALUE,
    input wire logic [31:0] LOAD_DATA,
    input wire logic EXCEPTION,
    output logic [31:0] PC,
    output logic [5:0] BASE_REG_SEL,
    output logic [5:0] RESULT_REG_SEL,
    output logic [3:0] CP_OPCODE,
    output logic [5:0] COPROC_REG_FIELD,
    output logic CP_XFER,
    output logic [31:0] ADDR_PINS,
    output logic ADDR_VALID,
    output logic CACHE_PROBE,
    output logic DWORD_ACCESS,
    output logic READ_ACCESS,
    output logic [31:0] STORE_DATA,
    output logic STORE_DRIVE,
    output logic REG_WE,
    output logic [5:0] REG_WADDR,
    output logic [31:0] REG_WDATA,
    output logic INTERRUPT_N
);
    typedef struct packed {
        logic [31:0] pc;
        logic [31:0] alu_instr;
        logic alu_valid;
        logic [31:0] alu_pc;
        logic [31:0] mem_instr;
        logic mem_valid;
        logic [31:0] mem_addr;
        logic [31:0] mem_sdata;
        logic [31:0] wb_instr;
        logic wb_valid;
        logic [31:0] wb_addr;
        logic [31:0] wb_sdata;
        logic pend_valid;
        logic [31:0] pend_pc;
        logic exc_seen;
        logic [5:0] base_sel;
        logic [5:0] res_sel;
        logic [3:0] cp_op;
        logic [5:0] cp_reg;
        logic cp_xfer;
        logic [31:0] addr_pins;
        logic addr_valid;
        logic probe;
        logic dword;
        logic rd;
        logic [31:0] sdata;
        logic sdrive;
        logic we;
        logic [5:0] waddr;
        logic [31:0] wdata;
        logic irq_n;
    } state_t;

    state_t s;
    state_t next_s;

    // effective address: word offset shifted left two, sign extended
    function automatic logic [31:0] eff_addr(input logic [31:0] ins, input logic [31:0] base);
        eff_addr = base + {{14{ins[DISP_MSB]}}, ins[DISP_MSB:DISP_LSB], 2'b00}; // [RULE_02]
    endfunction

    function automatic logic [3:0] opc(input logic [31:0] ins);
        opc = ins[OPC_MSB:OPC_LSB]; // [RULE_20]
    endfunction

    // nor of selected tests, or with sense bit set; top selector bits ignored
    function automatic logic cond_met(input logic [5:0] c, input logic [31:0] v);
        logic any;
        any = (c[COND_SEL_LSB] & v[0]) | (c[COND_SEL_NEG] & v[31]) // [RULE_13]
            | (c[COND_SEL_POS] & ~v[31] & (v != 32'h0000_0000));
        cond_met = c[COND_SENSE] ? any : ~any; // [RULE_14]
    endfunction

    logic [3:0] a_op;
    logic [3:0] m_op;
    logic [3:0] w_op;
    logic [31:0] ea;
    assign a_op = opc(s.alu_instr);
    assign m_op = opc(s.mem_instr);
    assign w_op = opc(s.wb_instr);
    assign ea = eff_addr(s.alu_instr, BASE_VALUE);

    // four stages advance every cycle; commit happens only in writeback
    always_comb begin
        next_s = s;
        // fetch -> compute [RULE_19]
        next_s.alu_instr = FETCH_INSTR;
        next_s.alu_valid = FETCH_VALID;
        next_s.alu_pc = s.pc;
        next_s.base_sel = FETCH_INSTR[BASE_MSB:BASE_LSB];
        next_s.res_sel = FETCH_INSTR[RES_MSB:RES_LSB];
        // pc: a pending target lands two instructions after its source
        if (s.pend_valid) begin
            next_s.pc = s.pend_pc; // [RULE_16]
        end else begin
            next_s.pc = s.pc + PC_STEP; // [RULE_12]
        end
        next_s.pend_valid = 1'b0;
        // compute stage: jump decision and coprocessor shipping
        next_s.cp_xfer = 1'b0;
        next_s.cp_op = 4'h0;
        next_s.cp_reg = 6'h00;
        if (s.alu_valid && a_op == OP_COND_JUMP
            && cond_met(s.alu_instr[RES_MSB:RES_LSB], BASE_VALUE)) begin
            next_s.pend_valid = 1'b1; // [RULE_11]
            next_s.pend_pc = eff_addr(s.alu_instr, s.alu_pc); // [RULE_11]
        end
        if (s.alu_valid && (a_op == OP_CP_STORE || a_op == OP_CP_LOAD)) begin
            next_s.cp_xfer = 1'b1; // [RULE_04]
            next_s.cp_op = a_op;
            next_s.cp_reg = s.alu_instr[RES_MSB:RES_LSB];
        end
        next_s.mem_instr = s.alu_instr;
        next_s.mem_valid = s.alu_valid;
        next_s.mem_sdata = RESULT_VALUE;
        unique case (a_op)
            OP_CP_STORE, OP_CP_LOAD: next_s.mem_addr = ea & DWORD_MASK; // [RULE_03] [RULE_05]
            OP_CPU_STORE, OP_CPU_LOAD: next_s.mem_addr = ea & WORD_MASK; // [RULE_06] [RULE_09]
            default: next_s.mem_addr = ea; // [RULE_15]
        endcase
        // cache access stage
        next_s.addr_valid = 1'b0;
        next_s.probe = 1'b0;
        next_s.dword = 1'b0;
        next_s.rd = 1'b0;
        next_s.addr_pins = 32'h0000_0000;
        if (s.mem_valid) begin
            case (m_op)
                OP_TEST, OP_CP_ALU: begin
                    next_s.addr_pins = s.mem_instr; // [RULE_01] [RULE_18]
                    next_s.addr_valid = 1'b1;
                end
                OP_CP_STORE, OP_CP_LOAD: begin
                    next_s.addr_pins = s.mem_addr; // [RULE_03] [RULE_05]
                    next_s.addr_valid = 1'b1;
                    next_s.dword = 1'b1;
                    next_s.rd = (m_op == OP_CP_LOAD);
                end
                OP_CPU_STORE, OP_CPU_LOAD: begin
                    next_s.addr_pins = s.mem_addr;
                    next_s.addr_valid = 1'b1;
                    next_s.probe = (m_op == OP_CPU_STORE); // [RULE_07]
                    next_s.rd = (m_op == OP_CPU_LOAD);
                end
                default: next_s.addr_valid = 1'b0;
            endcase
        end
        next_s.wb_instr = s.mem_instr;
        next_s.wb_valid = s.mem_valid;
        next_s.wb_addr = s.mem_addr;
        next_s.wb_sdata = s.mem_sdata;
        // writeback stage: store data out, register commit
        next_s.sdrive = s.wb_valid && w_op == OP_CPU_STORE; // [RULE_07]
        next_s.sdata = next_s.sdrive ? s.wb_sdata : 32'h0000_0000; // [RULE_06]
        next_s.we = 1'b0;
        next_s.waddr = s.wb_instr[RES_MSB:RES_LSB];
        next_s.wdata = 32'h0000_0000;
        if (s.wb_valid && w_op == OP_CPU_LOAD) begin
            next_s.we = 1'b1; // [RULE_09]
            next_s.wdata = LOAD_DATA;
        end else if (s.wb_valid && w_op == OP_ADD_IMM) begin
            next_s.we = 1'b1; // [RULE_15]
            next_s.wdata = s.wb_addr;
        end
        // exception line low two cycles after the event
        next_s.exc_seen = EXCEPTION;
        next_s.irq_n = ~s.exc_seen; // [RULE_17]
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            s <= '0;
            s.pc <= PC_RESET;
            s.irq_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // every output is a flip-flop of the state
    assign PC = s.pc;
    assign BASE_REG_SEL = s.base_sel;
    assign RESULT_REG_SEL = s.res_sel;
    assign CP_OPCODE = s.cp_op;
    assign COPROC_REG_FIELD = s.cp_reg;
    assign CP_XFER = s.cp_xfer;
    assign ADDR_PINS = s.addr_pins;
    assign ADDR_VALID = s.addr_valid;
    assign CACHE_PROBE = s.probe;
    assign DWORD_ACCESS = s.dword;
    assign READ_ACCESS = s.rd;
    assign STORE_DATA = s.sdata;
    assign STORE_DRIVE = s.sdrive;
    assign REG_WE = s.we;
    assign REG_WADDR = s.waddr;
    assign REG_WDATA = s.wdata;
    assign INTERRUPT_N = s.irq_n;
endmodule
`default_nettype wire

/* bench/lsb_far_end.sv */
`default_nettype none
module lsb_far_end (
    input wire logic CORE_CLK,
    input wire logic [5:0] BASE_REG_SEL,
    input wire logic [5:0] RESULT_REG_SEL,
    input wire logic [31:0] ADDR_PINS,
    input wire logic ADDR_VALID,
    input wire logic READ_ACCESS,
    input wire logic CACHE_PROBE,
    input wire logic STORE_DRIVE,
    input wire logic [31:0] STORE_DATA,
    output logic [31:0] BASE_VALUE,
    output logic [31:0] RESULT_VALUE,
    output logic [31:0] LOAD_DATA
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] noise = 32'h5a5a_5a5a;
    // base register n holds n sign-extended, so zero, odd, even and negative are reachable
    assign BASE_VALUE = {{26{BASE_REG_SEL[5]}}, BASE_REG_SEL};
    assign RESULT_VALUE = {26'h2aaaaaa, RESULT_REG_SEL};
    // idle read bus churns so a stale sample never matches
    always @(posedge CORE_CLK) noise <= ~noise + 32'h1;
    assign LOAD_DATA = ADDR_VALID && READ_ACCESS ? ~ADDR_PINS : noise;
    // cache unit: every probe hits here, so each store must reach the ram
    logic probe_hit = 1'b0;
    logic [31:0] cache_word = 32'h0000_0000;
    always @(posedge CORE_CLK) probe_hit <= CACHE_PROBE;
    // ram write in the late half of writeback, once the data bus has settled
    always @(negedge CORE_CLK) if (probe_hit && STORE_DRIVE) cache_word <= STORE_DATA;
endmodule
`default_nettype wire

/* bench/lsb_chk.sv */
`default_nettype none
module lsb_chk (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic EXCEPTION,
    input wire logic INTERRUPT_N,
    input wire logic CP_XFER,
    input wire logic ADDR_VALID,
    input wire logic [31:0] ADDR_PINS,
    input wire logic CACHE_PROBE,
    input wire logic DWORD_ACCESS,
    input wire logic READ_ACCESS,
    input wire logic STORE_DRIVE,
    input wire logic REG_WE,
    input wire logic [31:0] REG_WDATA,
    input wire logic [31:0] LOAD_DATA
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // stage follow-ups of each transfer
    chk_xfer_access: assert property (CP_XFER |=> ADDR_VALID && DWORD_ACCESS)
        else $error("no access after cp transfer");
    chk_probe_drive: assert property (CACHE_PROBE |=> STORE_DRIVE)
        else $error("no store data after probe");
    chk_drive_cause: assert property (STORE_DRIVE |-> $past(CACHE_PROBE))
        else $error("store data without probe");
    chk_probe_word: assert property (
        CACHE_PROBE |-> ADDR_VALID && !DWORD_ACCESS && !ADDR_PINS[1:0])
        else $error("bad store probe");
    chk_dword_align: assert property (ADDR_VALID && DWORD_ACCESS |-> !ADDR_PINS[2:0])
        else $error("doubleword misaligned");
    chk_load_wb: assert property (
        ADDR_VALID && READ_ACCESS && !DWORD_ACCESS |=> REG_WE && REG_WDATA == $past(LOAD_DATA))
        else $error("load data not written");
    // the line may lag by a cycle but never fires unprovoked
    chk_irq_pull: assert property (EXCEPTION |-> ##[1:2] !INTERRUPT_N)
        else $error("interrupt line not pulled");
    chk_irq_cause: assert property (
        $fell(INTERRUPT_N) |-> $past(EXCEPTION) || $past(EXCEPTION, 2))
        else $error("interrupt without cause");
endmodule
bind load_store_branch_execute lsb_chk i_chk (.*);
`default_nettype wire

/* bench/load_store_branch_execute_test.sv */
`default_nettype none
module load_store_branch_execute_test import lsb_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] OPS [7] = '{OP_CP_STORE, OP_CP_LOAD, OP_CPU_STORE, OP_CPU_LOAD,
        OP_ADD_IMM, OP_TEST, OP_CP_ALU};
    localparam logic [5:0] REGS [5] = '{6'h00, 6'h02, 6'h03, 6'h3e, 6'h3f};
    logic CORE_CLK = 0, RST = 1, FETCH_VALID = 0, EXCEPTION = 0, run = 0, exc_seen = 0, t;
    logic [31:0] FETCH_INSTR = '0, BASE_VALUE, RESULT_VALUE, LOAD_DATA, PC, ADDR_PINS, STORE_DATA;
    logic [31:0] REG_WDATA, pc_prev, a, v, last_st = '0;
    logic [5:0] BASE_REG_SEL, RESULT_REG_SEL, COPROC_REG_FIELD, REG_WADDR, r, b;
    logic [3:0] CP_OPCODE, op;
    logic [15:0] d;
    logic CP_XFER, ADDR_VALID, CACHE_PROBE, DWORD_ACCESS, READ_ACCESS, STORE_DRIVE, REG_WE;
    logic INTERRUPT_N;
    int n_errors = 0, num_checks = 0;
    logic [37:0] qa[$], qs[$], qw[$], qc[$], qj[$];
    load_store_branch_execute i_dut (.*);
    lsb_far_end i_far (.*);
    task automatic chk(input string name, input logic [37:0] exp, input logic [37:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic issue(input logic [31:0] instr);
        @(posedge CORE_CLK) #1;
        FETCH_VALID = 1;
        FETCH_INSTR = instr;
    endtask
    task automatic results();
        if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // scoreboard: oldest note against each result; jumps show as pc discontinuities
    always @(posedge CORE_CLK) begin
        if (!RST) begin
            if (ADDR_VALID) chk("addr", qa.size() ? qa.pop_front() : 'x, ADDR_PINS);
            if (CP_XFER) chk("cp", qc.size() ? qc.pop_front() : 'x, {CP_OPCODE, COPROC_REG_FIELD});
            if (STORE_DRIVE) chk("store", qs.size() ? qs.pop_front() : 'x, STORE_DATA);
            if (REG_WE) chk("wreg", qw.size() ? qw.pop_front() : 'x, {REG_WADDR, REG_WDATA});
            if (run && !exc_seen && PC !== pc_prev + 32'h1)
                chk("jump", qj.size() ? qj.pop_front() : 'x, PC);
        end
        pc_prev <= PC;
        run <= !RST;
    end
    initial forever #10 CORE_CLK = ~CORE_CLK;
    initial begin
        #100us;
        n_errors++;
        results();
    end
    initial begin
        void'($urandom(32'h651af677));
        repeat (6) @(posedge CORE_CLK);
        #1 RST = 0;
        chk("reset", {6'h1, 32'h0}, {5'h0, INTERRUPT_N, PC});
        // back-to-back traffic with random fields
        repeat (300) begin
            op = OPS[$urandom % 7];
            {r, b, d} = 28'($urandom);
            if (op == OP_CPU_LOAD && r == b) r = ~b;
            a = {{26{b[5]}}, b} + {{14{d[15]}}, d, 2'b00};
            issue({op, r, b, d});
            case (op)
                OP_CP_STORE, OP_CP_LOAD: begin
                    qa.push_back(a & DWORD_MASK);
                    qc.push_back({op, r});
                end
                OP_CPU_STORE: begin
                    qa.push_back(a & WORD_MASK);
                    qs.push_back({26'h2aaaaaa, r});
                    last_st = {26'h2aaaaaa, r};
                end
                OP_CPU_LOAD: begin
                    qa.push_back(a & WORD_MASK);
                    qw.push_back({r, ~(a & WORD_MASK)});
                end
                OP_ADD_IMM: qw.push_back({r, a});
                default: qa.push_back({op, r, b, d});
            endcase
        end
        // selectors 0 to 9 on zero, even, odd and negative operands, idle after each
        for (int c = 0; c < 10; c++) foreach (REGS[j]) begin
            d = ($urandom & 16'h80ff) | 16'h0100;
            v = {{26{REGS[j][5]}}, REGS[j]};
            t = (c[3] & v[0]) | (c[2] & v[31]) | (c[1] & (v != 0) & !v[31]);
            issue({OP_COND_JUMP, 2'($urandom), 4'(c), REGS[j], d});
            if (c[0] ? t : !t) qj.push_back(PC + {{14{d[15]}}, d, 2'b00});
            // delay slot: must commit whether or not the jump is taken
            issue({OP_ADD_IMM, 6'h01, REGS[j], 16'h0001});
            qw.push_back({6'h01, v + 32'h4});
            @(posedge CORE_CLK) #1 FETCH_VALID = 0;
            repeat (7) @(posedge CORE_CLK);
        end
        #1 exc_seen = 1;
        EXCEPTION = 1;
        @(posedge CORE_CLK) #1;
        EXCEPTION = 0;
        @(posedge CORE_CLK) #2;
        chk("irq", 0, INTERRUPT_N);
        chk("left", 0, 38'(qa.size() + qs.size() + qw.size() + qc.size() + qj.size()));
        chk("cache", last_st, i_far.cache_word);
        results();
    end
endmodule
`default_nettype wire
